/* File: hdl/tpc_pkg.sv */
// Register map, field positions and reset values of the PWM block
package tpc_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_CH = 3;
  localparam int NUM_OUT = 6;

  // Register byte offsets
  localparam logic [7:0] OFF_HALF_PERIOD = 8'h00;
  localparam logic [7:0] OFF_DEAD_TIME = 8'h04;
  localparam logic [7:0] OFF_DUTY0 = 8'h08;
  localparam logic [7:0] DUTY_STRIDE = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h14;
  localparam logic [7:0] OFF_OUT_EN = 8'h18;
  localparam logic [7:0] OFF_SWAP = 8'h1c;
  localparam logic [7:0] OFF_CHOP = 8'h20;
  localparam logic [7:0] OFF_INT_STATUS = 8'h24;
  localparam logic [7:0] OFF_INT_MASK = 8'h28;
  localparam logic [7:0] OFF_STATUS = 8'h2c;

  // Control register fields
  localparam int CTRL_RUN = 0;
  localparam int CTRL_EXT_SYNC = 1;
  localparam int CTRL_SW_TRIP = 2;
  localparam int CTRL_RELEASE = 3;

  // Chopper register fields
  localparam int CHOP_DIV_W = 8;
  localparam int CHOP_HI_EN = 8;
  localparam int CHOP_LO_EN = 9;

  // Interrupt status and mask fields
  localparam int INT_W = 2;
  localparam int INT_SYNC = 0;
  localparam int INT_SHUTDOWN = 1;

  // Status register fields
  localparam int STAT_SHUTDOWN = 0;
  localparam int STAT_DIR_UP = 1;
  localparam int STAT_TRIP = 2;
  localparam int STAT_CNT_LSB = 16;

  // Reset values
  localparam logic [15:0] HALF_PERIOD_RST = 16'h0100;
  localparam logic [9:0] DEAD_TIME_RST = 10'h000;
  localparam logic [15:0] DUTY_RST = 16'h0000;
  localparam logic [5:0] OUT_EN_RST = 6'h3f;
  localparam logic [7:0] CHOP_DIV_RST = 8'h00;

endpackage

/* File: hdl/tpc_sync2.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none

module tpc_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule

`default_nettype wire

/* File: hdl/tpc_dead_band.sv */
// Dead-time insertion for one complementary output pair
`timescale 1ns/1ns
`default_nettype none

module tpc_dead_band #(
  parameter int DT_W = 10
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic run_in,
  input wire logic raw_in,
  input wire logic [DT_W-1:0] dead_in,
  output logic high_out,
  output logic low_out
);

  logic prev_q;
  logic busy_q;
  logic tick_q;
  logic high_q;
  logic low_q;
  logic [DT_W-1:0] left_q;

  // Tick toggles every cycle, so one count of the dead time is two clocks
  always_ff @(posedge mclk_in) begin
    if (reset_in || !run_in) begin
      prev_q <= 1'b0;
      busy_q <= 1'b1;
      tick_q <= 1'b0;
      left_q <= '0;
      high_q <= 1'b0;
      low_q <= 1'b0;
    end else if (raw_in != prev_q) begin
      prev_q <= raw_in;
      tick_q <= 1'b1;
      left_q <= dead_in;
      busy_q <= (dead_in != '0);
      high_q <= (dead_in == '0) && raw_in;
      low_q <= (dead_in == '0) && !raw_in;
    end else if (busy_q) begin
      if (left_q == '0) begin
        busy_q <= 1'b0;
        high_q <= prev_q;
        low_q <= !prev_q;
      end else begin
        tick_q <= !tick_q;
        if (tick_q) begin
          left_q <= left_q - 1'b1;
        end
      end
    end
  end

  assign high_out = high_q;
  assign low_out = low_q;

  a_gap_open: assert property (
    @(posedge mclk_in) disable iff (reset_in)
    (run_in && raw_in != prev_q && dead_in != '0)
    |=> (!high_out && !low_out) [*2])
    else $error("pair not blanked for dead time");

endmodule

`default_nettype wire

/* File: hdl/tpc_pwm_top.sv */
// Three-phase centre-aligned PWM generator with trip shutdown and IRQ
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

module tpc_pwm_top #(
  parameter int CNT_W = 16,
  parameter int DT_W = 10
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic trip_n_in,
  input wire logic ext_sync_in,
  output logic [2:0] phase_high_out,
  output logic [2:0] phase_low_out,
  output logic period_sync_out,
  output logic irq_out
);

  if (CNT_W < 2 || CNT_W > 16 || DT_W < 1 || DT_W > 16) begin : g_bad
    $error("tpc_pwm_top: CNT_W must be 2..16, DT_W 1..16");
  end

  // Configuration registers
  logic [CNT_W-1:0] half_q;
  logic [DT_W-1:0] dead_q;
  logic [CNT_W-1:0] duty_q [tpc_pkg::NUM_CH];
  logic [CNT_W-1:0] duty_sh_q [tpc_pkg::NUM_CH];
  logic run_q;
  logic ext_sel_q;
  logic [tpc_pkg::NUM_OUT-1:0] oen_q;
  logic [tpc_pkg::NUM_CH-1:0] swap_q;
  logic [tpc_pkg::CHOP_DIV_W-1:0] chop_div_q;
  logic chop_hi_q;
  logic chop_lo_q;
  logic [tpc_pkg::INT_W-1:0] int_st_q;
  logic [tpc_pkg::INT_W-1:0] int_mask_q;
  logic irq_q;
  logic [31:0] rdata_q;

  // Timing unit state
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_inc;
  logic dir_up_q;
  logic run_t;
  logic sync_pulse;

  // Shutdown and pins
  logic sd_q;
  logic sd_set;
  logic sd_event;
  logic [1:0] pins_s;
  logic trip_n_s;
  logic ext_s;
  logic ext_prev_q;
  logic ext_rise;

  // Chopper
  logic [tpc_pkg::CHOP_DIV_W-1:0] chop_cnt_q;
  logic chop_wave_q;

  // Per-channel outputs
  logic [tpc_pkg::NUM_CH-1:0] raw;
  logic [tpc_pkg::NUM_CH-1:0] hi_tu;
  logic [tpc_pkg::NUM_CH-1:0] lo_tu;
  logic [tpc_pkg::NUM_CH-1:0] ph_hi_q;
  logic [tpc_pkg::NUM_CH-1:0] ph_lo_q;

  // Bus decode
  logic wr_ctrl;
  logic sw_trip;
  logic release_req;
  logic [tpc_pkg::INT_W-1:0] int_clear;
  logic [tpc_pkg::INT_W-1:0] int_event;

  assign wr_ctrl = wr_in && (addr_in == tpc_pkg::OFF_CTRL);
  assign sw_trip = wr_ctrl && wdata_in[tpc_pkg::CTRL_SW_TRIP];
  assign release_req = wr_ctrl && wdata_in[tpc_pkg::CTRL_RELEASE];
  assign int_clear = (wr_in && addr_in == tpc_pkg::OFF_INT_STATUS) ?
                     wdata_in[tpc_pkg::INT_W-1:0] : '0;

  // Trip idles high so the synchroniser resets to the released level
  tpc_sync2 #(
    .W(2),
    .RST_VAL(2'b10)
  ) u_pin_sync (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .async_in({trip_n_in, ext_sync_in}),
    .sync_out(pins_s)
  );

  assign trip_n_s = pins_s[1];
  assign ext_s = pins_s[0];
  assign ext_rise = ext_s && !ext_prev_q;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      ext_prev_q <= 1'b0;
    end else begin
      ext_prev_q <= ext_s;
    end
  end

  // Software registers
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      half_q <= CNT_W'(tpc_pkg::HALF_PERIOD_RST);
      dead_q <= DT_W'(tpc_pkg::DEAD_TIME_RST);
      run_q <= 1'b0;
      ext_sel_q <= 1'b0;
      oen_q <= tpc_pkg::OUT_EN_RST;
      swap_q <= '0;
      chop_div_q <= tpc_pkg::CHOP_DIV_RST;
      chop_hi_q <= 1'b0;
      chop_lo_q <= 1'b0;
      int_mask_q <= '0;
    end else if (wr_in) begin
      case (addr_in)
        tpc_pkg::OFF_HALF_PERIOD: begin
          half_q <= wdata_in[CNT_W-1:0];
        end
        tpc_pkg::OFF_DEAD_TIME: begin
          dead_q <= wdata_in[DT_W-1:0];
        end
        tpc_pkg::OFF_CTRL: begin
          run_q <= wdata_in[tpc_pkg::CTRL_RUN];
          ext_sel_q <= wdata_in[tpc_pkg::CTRL_EXT_SYNC];
        end
        tpc_pkg::OFF_OUT_EN: begin
          oen_q <= wdata_in[tpc_pkg::NUM_OUT-1:0];
        end
        tpc_pkg::OFF_SWAP: begin
          swap_q <= wdata_in[tpc_pkg::NUM_CH-1:0];
        end
        tpc_pkg::OFF_CHOP: begin
          chop_div_q <= wdata_in[tpc_pkg::CHOP_DIV_W-1:0];
          chop_hi_q <= wdata_in[tpc_pkg::CHOP_HI_EN];
          chop_lo_q <= wdata_in[tpc_pkg::CHOP_LO_EN];
        end
        tpc_pkg::OFF_INT_MASK: begin
          int_mask_q <= wdata_in[tpc_pkg::INT_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Shutdown controller: a new trip wins over a release in the same cycle
  assign sd_set = !trip_n_s || sw_trip;
  assign sd_event = sd_set && !sd_q;
  assign run_t = run_q && !sd_q;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      sd_q <= 1'b0;
    end else if (sd_set) begin
      sd_q <= 1'b1;
    end else if (release_req) begin
      sd_q <= 1'b0;
    end
  end

  // Up/down counter: 0 up to half, back down to 0, 2*half cycles a period
  assign cnt_inc = cnt_q + 1'b1;
  assign sync_pulse = run_t && (cnt_q == '0) && dir_up_q;

  // Half period values 0 and 1 are not supported; software avoids them
  always_ff @(posedge mclk_in) begin
    if (reset_in || !run_t) begin
      cnt_q <= '0;
      dir_up_q <= 1'b1;
    end else if (ext_sel_q && ext_rise) begin
      cnt_q <= '0;
      dir_up_q <= 1'b1;
    end else if (dir_up_q) begin
      cnt_q <= cnt_inc;
      if (cnt_inc >= half_q) begin
        dir_up_q <= 1'b0;
      end
    end else begin
      cnt_q <= cnt_q - 1'b1;
      if (cnt_q == CNT_W'(1)) begin
        dir_up_q <= 1'b1;
      end
    end
  end

  // Chopper: wave period is 2*(div+1) core cycles
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      chop_cnt_q <= '0;
      chop_wave_q <= 1'b0;
    end else if (chop_cnt_q >= chop_div_q) begin
      chop_cnt_q <= '0;
      chop_wave_q <= !chop_wave_q;
    end else begin
      chop_cnt_q <= chop_cnt_q + 1'b1;
    end
  end

  // Per-channel compare, dead band and output stage
  for (genvar i = 0; i < tpc_pkg::NUM_CH; i++) begin : g_ch
    logic hi_sel;
    logic lo_sel;

    // Duty is taken only at period start or while stopped, so a pulse never tears mid-period
    always_ff @(posedge mclk_in) begin
      if (reset_in) begin
        duty_q[i] <= CNT_W'(tpc_pkg::DUTY_RST);
      end else if (wr_in && addr_in == 8'(tpc_pkg::OFF_DUTY0 +
                   8'(i) * tpc_pkg::DUTY_STRIDE)) begin
        duty_q[i] <= wdata_in[CNT_W-1:0];
      end
    end

    always_ff @(posedge mclk_in) begin
      if (reset_in) begin
        duty_sh_q[i] <= CNT_W'(tpc_pkg::DUTY_RST);
      end else if (sync_pulse || !run_t) begin
        duty_sh_q[i] <= duty_q[i];
      end
    end

    // Pulse is symmetric about the counter's zero point
    assign raw[i] = duty_sh_q[i] > cnt_q;

    tpc_dead_band #(
      .DT_W(DT_W)
    ) u_dead (
      .mclk_in(mclk_in),
      .reset_in(reset_in),
      .run_in(run_t),
      .raw_in(raw[i]),
      .dead_in(dead_q),
      .high_out(hi_tu[i]),
      .low_out(lo_tu[i])
    );

    assign hi_sel = swap_q[i] ? lo_tu[i] : hi_tu[i];
    assign lo_sel = swap_q[i] ? hi_tu[i] : lo_tu[i];

    always_ff @(posedge mclk_in) begin
      if (reset_in || sd_q) begin
        ph_hi_q[i] <= 1'b0;
        ph_lo_q[i] <= 1'b0;
      end else begin
        ph_hi_q[i] <= hi_sel && oen_q[i] &&
                      (!chop_hi_q || chop_wave_q);
        ph_lo_q[i] <= lo_sel && oen_q[i + tpc_pkg::NUM_CH] &&
                      (!chop_lo_q || chop_wave_q);
      end
    end
  end

  assign phase_high_out = ph_hi_q;
  assign phase_low_out = ph_lo_q;
  assign period_sync_out = sync_pulse;

  // Interrupts: sticky, write one to clear, a new event wins over a clear
  assign int_event[tpc_pkg::INT_SYNC] = sync_pulse;
  assign int_event[tpc_pkg::INT_SHUTDOWN] = sd_event;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      int_st_q <= '0;
    end else begin
      int_st_q <= (int_st_q & ~int_clear) | int_event;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(int_st_q & int_mask_q);
    end
  end

  assign irq_out = irq_q;

  // Read port: data valid only in the cycle after the strobe
  always_ff @(posedge mclk_in) begin
    if (reset_in || !rd_in) begin
      rdata_q <= '0;
    end else begin
      case (addr_in)
        tpc_pkg::OFF_HALF_PERIOD: rdata_q <= 32'(half_q);
        tpc_pkg::OFF_DEAD_TIME: rdata_q <= 32'(dead_q);
        tpc_pkg::OFF_DUTY0: rdata_q <= 32'(duty_q[0]);
        8'(tpc_pkg::OFF_DUTY0 + tpc_pkg::DUTY_STRIDE):
          rdata_q <= 32'(duty_q[1]);
        8'(tpc_pkg::OFF_DUTY0 + 8'h2 * tpc_pkg::DUTY_STRIDE):
          rdata_q <= 32'(duty_q[2]);
        tpc_pkg::OFF_CTRL: begin
          rdata_q <= '0;
          rdata_q[tpc_pkg::CTRL_RUN] <= run_q;
          rdata_q[tpc_pkg::CTRL_EXT_SYNC] <= ext_sel_q;
        end
        tpc_pkg::OFF_OUT_EN: rdata_q <= 32'(oen_q);
        tpc_pkg::OFF_SWAP: rdata_q <= 32'(swap_q);
        tpc_pkg::OFF_CHOP: begin
          rdata_q <= 32'(chop_div_q);
          rdata_q[tpc_pkg::CHOP_HI_EN] <= chop_hi_q;
          rdata_q[tpc_pkg::CHOP_LO_EN] <= chop_lo_q;
        end
        tpc_pkg::OFF_INT_STATUS: rdata_q <= 32'(int_st_q);
        tpc_pkg::OFF_INT_MASK: rdata_q <= 32'(int_mask_q);
        tpc_pkg::OFF_STATUS: begin
          rdata_q <= '0;
          rdata_q[tpc_pkg::STAT_SHUTDOWN] <= sd_q;
          rdata_q[tpc_pkg::STAT_DIR_UP] <= dir_up_q;
          rdata_q[tpc_pkg::STAT_TRIP] <= !trip_n_s;
          rdata_q[tpc_pkg::STAT_CNT_LSB +: CNT_W] <= cnt_q;
        end
        default: rdata_q <= '0;
      endcase
    end
  end

  assign rdata_out = rdata_q;

  // Checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  a_sync_irq: assert property (
    sync_pulse |=> int_st_q[tpc_pkg::INT_SYNC])
    else $error("sync pulse did not set its status bit");

  a_sd_irq: assert property (
    sd_event |=> int_st_q[tpc_pkg::INT_SHUTDOWN] && sd_q)
    else $error("shutdown did not set its status bit");

  a_trip_latch: assert property (
    !trip_n_s |=> sd_q && !run_t ##1 cnt_q == '0)
    else $error("trip did not stop the timing unit");

  a_sd_quiet: assert property (
    sd_q |=> phase_high_out == '0 && phase_low_out == '0)
    else $error("outputs active during shutdown");

  a_no_overlap: assert property (
    (phase_high_out & phase_low_out) == '0)
    else $error("both sides of a pair active");

  a_cnt_turn: assert property (
    (run_t && dir_up_q && !(ext_sel_q && ext_rise) && cnt_inc == half_q)
    |=> !dir_up_q && cnt_q == $past(half_q))
    else $error("counter did not turn at half period");

  a_rd_half: assert property (
    (rd_in && addr_in == tpc_pkg::OFF_HALF_PERIOD)
    |=> rdata_out == 32'($past(half_q))
    ##1 ($past(rd_in) || rdata_out == '0))
    else $error("half period read back wrong");

  a_rd_dead: assert property (
    (rd_in && addr_in == tpc_pkg::OFF_DEAD_TIME)
    |=> rdata_out == 32'($past(dead_q)))
    else $error("dead time read back wrong");

  c_sync: cover property ((ext_sel_q && ext_rise) ##1 sync_pulse);
  c_trip: cover property (sd_event ##[1:50] release_req);
  c_turn: cover property (dir_up_q ##1 !dir_up_q);

endmodule

`default_nettype wire

/* File: tb/tpc_gate_model.sv */
// Gate-driver model: trip source and leg overlap monitor
`timescale 1ns/1ns
`default_nettype none

module tpc_gate_model (
  input wire logic mclk_in,
  input wire logic [2:0] high_in,
  input wire logic [2:0] low_in,
  input wire logic fault_in,
  output logic trip_n_out,
  output var int overlap_out
);
  // Trip line is pulled up; the driver stage can only pull it low
  assign trip_n_out = fault_in ? 1'b0 : 1'b1;

  initial overlap_out = 0;

  // Both switches of one leg on together would short the dc link
  always @(posedge mclk_in) begin
    if ((high_in & low_in) != 3'h0) begin
      overlap_out <= overlap_out + 1;
    end
  end
endmodule

`default_nettype wire

/* File: tb/three_phase_pwm_controller_tb.sv */
// Self-checking bench for the three-phase PWM block
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, exp, got) begin \
  comparisons++; \
  if ((got) !== (exp)) begin \
    bad_count++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, exp, got); \
  end \
end

module three_phase_pwm_controller_tb;
  logic mclk_in, reset_in, wr_in, rd_in, trip_n_in, ext_sync_in, fault;
  logic [7:0] addr_in;
  logic [31:0] wdata_in, rdata_out, d;
  logic [2:0] hi, lo;
  logic sync, irq;
  logic [6:0] any_on;
  int bad_count, comparisons, ovl, n, k, hc, lc, rs;

  tpc_pwm_top i_tpc_pwm_top (.mclk_in(mclk_in), .reset_in(reset_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .trip_n_in(trip_n_in),
    .ext_sync_in(ext_sync_in), .phase_high_out(hi), .phase_low_out(lo),
    .period_sync_out(sync), .irq_out(irq));

  tpc_gate_model i_tpc_gate_model (.mclk_in(mclk_in), .high_in(hi),
    .low_in(lo), .fault_in(fault), .trip_n_out(trip_n_in),
    .overlap_out(ovl));

  initial begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge mclk_in);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask

  // Read data only stands in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1;
    d = rdata_out;
  endtask

  function automatic logic pick(input int w);
    return (w == 0) ? hi[0] : (w == 1) ? lo[0] : sync;
  endfunction

  // Bounded wait; n gives the cycles spent
  task automatic wait_for(input int w, input logic v);
    n = 0;
    while (pick(w) !== v && n < 200) begin
      cyc(1);
      n++;
    end
  endtask

  // One full period of 16 samples for H = 8
  task automatic window;
    logic p;
    hc = 0;
    lc = 0;
    rs = 0;
    any_on = '0;
    p = hi[0];
    repeat (16) begin
      cyc(1);
      hc += hi[0];
      lc += lo[0];
      rs += (hi[0] & !p);
      p = hi[0];
      any_on |= {sync, lo, hi};
    end
  endtask

  initial begin
    reset_in = 1'b1;
    wr_in = 1'b0;
    rd_in = 1'b0;
    addr_in = 8'h00;
    wdata_in = 32'h0;
    ext_sync_in = 1'b0;
    fault = 1'b0;
    bad_count = 0;
    comparisons = 0;
    repeat (12) @(posedge mclk_in);
    reset_in <= 1'b0;
    rd(tpc_pkg::OFF_HALF_PERIOD);
    `CHK("half reset", 32'h100, d)
    rd(tpc_pkg::OFF_DEAD_TIME);
    `CHK("dead reset", 32'h0, d)
    rd(tpc_pkg::OFF_OUT_EN);
    `CHK("enable reset", 32'h3f, d)
    rd(8'hfc);
    `CHK("unmapped", 32'h0, d)
    wr(tpc_pkg::OFF_HALF_PERIOD, 32'hffffffff);
    rd(tpc_pkg::OFF_HALF_PERIOD);
    `CHK("half max", 32'hffff, d)
    wr(tpc_pkg::OFF_DEAD_TIME, 32'hffff);
    rd(tpc_pkg::OFF_DEAD_TIME);
    `CHK("dead width", 32'h3ff, d)
    // Half period 8, dead 1 (gap 2), duty 4 on every channel
    wr(tpc_pkg::OFF_HALF_PERIOD, 32'h8);
    wr(tpc_pkg::OFF_DEAD_TIME, 32'h1);
    for (k = 0; k < 3; k++) begin
      wr(tpc_pkg::OFF_DUTY0 + tpc_pkg::DUTY_STRIDE * 8'(k), 32'h4);
    end
    wr(tpc_pkg::OFF_INT_MASK, 32'h1);
    wr(tpc_pkg::OFF_CTRL, 32'h1);
    wait_for(2, 1'b1);
    cyc(1);
    wait_for(2, 1'b1);
    `CHK("period", 16, n + 1)
    cyc(2);
    `CHK("irq sync", 1'b1, irq)
    rd(tpc_pkg::OFF_INT_STATUS);
    `CHK("sync flag", 32'h1, d)
    wr(tpc_pkg::OFF_INT_MASK, 32'h0);
    wr(tpc_pkg::OFF_INT_STATUS, 32'h1);
    cyc(2);
    `CHK("irq masked", 1'b0, irq)
    window;
    `CHK("high width", 5, hc)
    `CHK("low width", 7, lc)
    `CHK("one pulse", 1, rs)
    wait_for(0, 1'b1);
    wait_for(0, 1'b0);
    wait_for(1, 1'b1);
    `CHK("gap high low", 2, n)
    wait_for(1, 1'b0);
    wait_for(0, 1'b1);
    `CHK("gap low high", 2, n)
    wr(tpc_pkg::OFF_SWAP, 32'h1);
    cyc(4);
    window;
    `CHK("swap high", 7, hc)
    `CHK("swap low", 5, lc)
    wr(tpc_pkg::OFF_SWAP, 32'h0);
    for (k = 0; k < 6; k++) begin
      wr(tpc_pkg::OFF_OUT_EN, 32'h1 << k);
      cyc(2);
      window;
      `CHK("enable others", 6'h0, any_on[5:0] & ~(6'h1 << k))
      `CHK("enable own", 1'b1, any_on[k])
    end
    wr(tpc_pkg::OFF_OUT_EN, 32'h3f);
    wr(tpc_pkg::OFF_CHOP, 32'h100);
    cyc(2);
    window;
    `CHK("chop toggles", 1'b1, rs > 1)
    // Low sides chopped with a slower wave, high sides left alone
    wr(tpc_pkg::OFF_CHOP, 32'h203);
    cyc(2);
    window;
    `CHK("chop low", 1'b1, lc > 2 && lc < 5)
    `CHK("chop spares high", 5, hc)
    wr(tpc_pkg::OFF_CHOP, 32'h0);
    // External edge mid-period must restart well before the natural sync
    wr(tpc_pkg::OFF_CTRL, 32'h3);
    wait_for(2, 1'b1);
    cyc(4);
    @(posedge mclk_in);
    ext_sync_in <= 1'b1;
    cyc(1);
    wait_for(2, 1'b1);
    `CHK("ext sync", 1'b1, n < 8)
    @(posedge mclk_in);
    ext_sync_in <= 1'b0;
    wr(tpc_pkg::OFF_CTRL, 32'h1);
    wr(tpc_pkg::OFF_INT_STATUS, 32'h3);
    wr(tpc_pkg::OFF_INT_MASK, 32'h2);
    @(posedge mclk_in);
    fault <= 1'b1;
    cyc(6);
    window;
    `CHK("trip quiet", 7'h0, any_on)
    `CHK("irq trip", 1'b1, irq)
    rd(tpc_pkg::OFF_INT_STATUS);
    `CHK("trip flag", 1'b1, d[1])
    wr(tpc_pkg::OFF_CTRL, 32'h9);
    rd(tpc_pkg::OFF_STATUS);
    `CHK("hold on trip", 1'b1, d[0])
    @(posedge mclk_in);
    fault <= 1'b0;
    cyc(4);
    wr(tpc_pkg::OFF_CTRL, 32'h9);
    rd(tpc_pkg::OFF_STATUS);
    `CHK("released", 1'b0, d[0])
    wait_for(0, 1'b1);
    `CHK("resume", 1'b1, n < 40)
    wr(tpc_pkg::OFF_INT_STATUS, 32'h2);
    cyc(2);
    `CHK("irq cleared", 1'b0, irq)
    wr(tpc_pkg::OFF_CTRL, 32'h5);
    rd(tpc_pkg::OFF_STATUS);
    `CHK("soft trip", 1'b1, d[0])
    rd(tpc_pkg::OFF_INT_STATUS);
    `CHK("soft trip flag", 1'b1, d[1])
    `CHK("overlap", 0, ovl)
    tally_and_finish;
  end

  // Whole sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge mclk_in);
    bad_count++;
    tally_and_finish;
  end
endmodule

`default_nettype wire
